/* src/flash_seq_pkg.sv */
// constants for the flash command sequencer: commands, addresses, timers
// assumes a 10 MHz core clock
package flash_seq_pkg;

    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned SECT_BITS = 4;
    localparam int unsigned WORD_BITS = 8;
    localparam int unsigned ADDR_BITS = SECT_BITS + WORD_BITS;

    localparam logic [11:0] UNLOCK1_ADDR = 12'h0_AAA;
    localparam logic [11:0] UNLOCK2_ADDR = 12'h0_554;
    localparam logic [7:0]  CMD_UNLOCK1  = 8'h00_AA;
    localparam logic [7:0]  CMD_UNLOCK2  = 8'h00_55;
    localparam logic [7:0]  CMD_BYPASS   = 8'h00_20;
    localparam logic [7:0]  CMD_PROGRAM  = 8'h00_A0;
    localparam logic [7:0]  CMD_BYP_EXIT = 8'h00_90;
    localparam logic [7:0]  CMD_BYP_EXIT2 = 8'h00_00;
    localparam logic [7:0]  CMD_ERASE    = 8'h00_80;
    localparam logic [7:0]  CMD_BULK     = 8'h00_10;
    localparam logic [7:0]  CMD_SECTOR   = 8'h00_30;
    localparam logic [7:0]  CMD_SUSPEND  = 8'h00_B0;
    localparam logic [7:0]  CMD_RESUME   = 8'h00_30;
    localparam logic [7:0]  CMD_RESET    = 8'h00_F0;

    localparam int unsigned POLL_BIT   = 7;
    localparam int unsigned TOGGLE_BIT = 6;
    localparam int unsigned ERROR_BIT  = 5;
    localparam int unsigned WINDOW_BIT = 3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // times in microseconds, cycle counts derived from the clock rate
    localparam int unsigned WINDOW_US   = 100;
    localparam int unsigned WINDOW_CYC  = WINDOW_US * CLK_MHZ;
    localparam int unsigned SUSPEND_US  = 15;
    localparam int unsigned SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
    localparam int unsigned PROG_US     = 10;
    localparam int unsigned PROG_CYC    = PROG_US * CLK_MHZ;
    localparam int unsigned PROG_TO_US  = 50;
    localparam int unsigned PROG_TO_CYC = PROG_TO_US * CLK_MHZ;
    localparam int unsigned PRE_CYC     = 4;

    typedef logic [15:0] word_t;
    typedef logic [ADDR_BITS-1:0] addr_t;

endpackage : flash_seq_pkg

/* src/flash_array_mem.sv */
// flash array storage: one write port, registered read data
// assumes single clock, writes only from the sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_array_mem (
    input  wire logic                         core_clk,
    input  wire logic                         we,
    input  wire flash_seq_pkg::addr_t         waddr,
    input  wire flash_seq_pkg::word_t         wdata,
    input  wire flash_seq_pkg::addr_t         raddr,
    output var        flash_seq_pkg::word_t   rdata_q
);
    import flash_seq_pkg::*;

    word_t mem [0:(1<<ADDR_BITS)-1];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : flash_array_mem
`default_nettype wire

/* src/flash_program_erase_sequencer.sv */
// flash command sequencer with embedded program/erase and status bits
// assumes the bus strobes are synchronous one-cycle pulses; selects are pins
//
// Contract
// - erase sets ones, program clears bits only
// - program read gives inverted bit 7
// - error on timeout or zero-to-one write
// - erase poll bit reads zero in sector
// - toggle inverts each read while busy
// - erase toggle on reads in sector
// - two unlocks then 20h enters bypass
// - bypass program is A0h then data
// - bypass accepts only program and exit
// - 90h then 00h leaves bypass
// - wrong bulk erase byte aborts to read
// - bulk erase rejects all commands
// - erase preprograms cells to zero first
// - extra sector writes restart erase window
// - window bit zero counting, one erasing
// - other command in window but B0h suspend cancels erase
// - erasing accepts only reset and suspend
// - B0h suspends sector erase, ends window
// - toggle stops within 15 us of suspend
// - suspended: program refused, erasing sector invalid
// - 30h resumes suspended erase
// - unlocks are AAh@AAAh, 55h@554h
// - status valid after fourth/sixth write
// - protected sector commands are ignored; a sector erase on one still opens or restarts the erase window
// - error bit holds until reset command
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer #(
    parameter int unsigned ERASE_CYC = 5000
) (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic                         main_sector_select,
    input  wire logic                         secondary_sector_select,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    input  wire flash_seq_pkg::addr_t         addr,
    input  wire flash_seq_pkg::word_t         wdata,
    input  wire logic [15:0]                  sector_protect,
    output var        flash_seq_pkg::word_t   rdata_q,
    output logic                              rvalid_q,
    output logic                              busy
);
    import flash_seq_pkg::*;

    typedef enum logic [4:0] {
        S_READ, S_U1, S_U2, S_PROG_ARM, S_E3, S_E4, S_E5, S_BYPASS, S_BYP_ARM,
        S_BYP_EXIT, S_PROG_RUN, S_BULK_RUN, S_WINDOW, S_SECT_RUN, S_SUSP_WAIT,
        S_SUSPENDED, S_ERR
    } state_t;

    function automatic logic is_at(input addr_t a, input logic [11:0] target);
        is_at = (a[ADDR_BITS-1:0] == target[ADDR_BITS-1:0]);
    endfunction : is_at

    function automatic logic [SECT_BITS-1:0] sect_of(input addr_t a);
        sect_of = a[ADDR_BITS-1:WORD_BITS];
    endfunction : sect_of

    logic sel_s1_q, sel_s2_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
        end else begin
            sel_s1_q <= main_sector_select | secondary_sector_select;
            sel_s2_q <= sel_s1_q;
        end
    end

    wire logic wr_ok = wr_stb & sel_s2_q;
    wire logic [7:0] cmd = wdata[7:0];

    state_t               state_q, state_d;
    logic [15:0]          erase_set_q, erase_set_d;
    logic [31:0]          timer_q, timer_d;
    logic [WORD_BITS:0]   walk_q, walk_d;
    logic                 pre_q, pre_d;
    logic                 err_q, err_d;
    logic                 tog_q, tog_d;
    logic                 bypass_q, bypass_d;
    addr_t                paddr_q, paddr_d;
    word_t                pdata_q, pdata_d;
    logic                 mem_we;
    addr_t                mem_waddr;
    word_t                mem_wdata;
    word_t                mem_rdata;
    logic                 rd_d1_q;
    addr_t                raddr_q;
    // program check must see the target word, not the bus address
    wire addr_t           mem_raddr = (state_q == S_PROG_RUN) ? paddr_q : addr;

    flash_array_mem u_mem (
        .core_clk (core_clk),
        .we       (mem_we),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .raddr    (mem_raddr),
        .rdata_q  (mem_rdata)
    );

    wire logic erasing = (state_q == S_BULK_RUN) || (state_q == S_SECT_RUN);
    wire logic running = erasing || (state_q == S_PROG_RUN) || (state_q == S_SUSP_WAIT);
    assign busy = running || (state_q == S_WINDOW);

    // return to read or bypass idle once idle
    function automatic state_t idle_state(input logic byp);
        idle_state = byp ? S_BYPASS : S_READ;
    endfunction : idle_state

    always_comb begin
        state_d     = state_q;
        erase_set_d = erase_set_q;
        timer_d     = timer_q;
        walk_d      = walk_q;
        pre_d       = pre_q;
        err_d       = err_q;
        tog_d       = tog_q;
        bypass_d    = bypass_q;
        paddr_d     = paddr_q;
        pdata_d     = pdata_q;
        mem_we      = 1'b0;
        mem_waddr   = paddr_q;
        mem_wdata   = pdata_q;
        if (rd_stb && busy) begin
            tog_d = ~tog_q;
        end
        unique case (state_q)
            S_READ: begin
                if (wr_ok) begin
                    if (cmd == CMD_UNLOCK1 && is_at(addr, UNLOCK1_ADDR)) begin
                        state_d = S_U1;
                    end
                end
            end
            S_U1: begin
                if (wr_ok) begin
                    state_d = (cmd == CMD_UNLOCK2 && is_at(addr, UNLOCK2_ADDR))
                        ? S_U2 : S_READ;
                end
            end
            S_U2: begin
                if (wr_ok) begin
                    unique case (cmd)
                        CMD_PROGRAM: state_d = S_PROG_ARM;
                        CMD_BYPASS: begin
                            bypass_d = 1'b1;
                            state_d  = S_BYPASS;
                        end
                        CMD_ERASE: state_d = S_E3;
                        default: state_d = S_READ;
                    endcase
                end
            end
            S_E3: begin
                if (wr_ok) begin
                    state_d = (cmd == CMD_UNLOCK1 && is_at(addr, UNLOCK1_ADDR))
                        ? S_E4 : S_READ;
                end
            end
            S_E4: begin
                if (wr_ok) begin
                    state_d = (cmd == CMD_UNLOCK2 && is_at(addr, UNLOCK2_ADDR))
                        ? S_E5 : S_READ;
                end
            end
            S_E5: begin
                if (wr_ok) begin
                    state_d = S_READ;
                    walk_d  = '0;
                    paddr_d = '0;
                    pre_d   = 1'b1;
                    if (cmd == CMD_BULK && is_at(addr, UNLOCK1_ADDR)) begin
                        erase_set_d = ~sector_protect;
                        state_d     = (~sector_protect == '0) ? S_READ : S_BULK_RUN;
                        timer_d     = '0;
                    end else if (cmd == CMD_SECTOR) begin
                        erase_set_d = '0;
                        erase_set_d[sect_of(addr)] = ~sector_protect[sect_of(addr)];
                        timer_d = WINDOW_CYC;
                        state_d = S_WINDOW;
                    end
                end
            end
            S_PROG_ARM, S_BYP_ARM: begin
                if (wr_ok) begin
                    paddr_d = addr;
                    pdata_d = wdata;
                    timer_d = '0;
                    if (sector_protect[sect_of(addr)]) begin
                        state_d = idle_state(bypass_q);
                    end else begin
                        state_d = S_PROG_RUN;
                    end
                end
            end
            S_BYPASS: begin
                if (wr_ok) begin
                    if (cmd == CMD_PROGRAM) begin
                        state_d = S_BYP_ARM;
                    end else if (cmd == CMD_BYP_EXIT) begin
                        state_d = S_BYP_EXIT;
                    end
                end
            end
            S_BYP_EXIT: begin
                if (wr_ok) begin
                    if (cmd == CMD_BYP_EXIT2) begin
                        bypass_d = 1'b0;
                        state_d  = S_READ;
                    end else begin
                        state_d = S_BYPASS;
                    end
                end
            end
            S_PROG_RUN: begin
                timer_d = timer_q + 32'd1;
                if ((~mem_rdata & pdata_q) != '0) begin
                    err_d   = 1'b1;
                    state_d = S_ERR;
                end else if (timer_q >= PROG_TO_CYC) begin
                    err_d   = 1'b1;
                    state_d = S_ERR;
                end else if (timer_q == PROG_CYC) begin
                    mem_we    = 1'b1;
                    mem_wdata = mem_rdata & pdata_q;
                    state_d   = idle_state(bypass_q);
                end
            end
            S_WINDOW: begin
                timer_d = timer_q - 32'd1;
                if (wr_ok) begin
                    if (cmd == CMD_SECTOR) begin
                        erase_set_d[sect_of(addr)] = ~sector_protect[sect_of(addr)];
                        timer_d = WINDOW_CYC;
                    end else if (cmd == CMD_SUSPEND && !addr[0]) begin
                        timer_d = SUSPEND_CYC - 1;
                        state_d = S_SUSP_WAIT;
                    end else begin
                        state_d = S_READ;
                    end
                end else if (timer_q == 32'd0) begin
                    state_d = (erase_set_q == '0) ? S_READ : S_SECT_RUN;
                    timer_d = '0;
                end
            end
            S_BULK_RUN, S_SECT_RUN: begin
                timer_d = timer_q + 32'd1;
                if (pre_q) begin
                    // preprogram to zero, then wipe to ones
                    if (erase_set_q[sect_of(paddr_q)]) begin
                        mem_we    = 1'b1;
                        mem_wdata = '0;
                    end
                end else if (erase_set_q[sect_of(paddr_q)]) begin
                    mem_we    = 1'b1;
                    mem_wdata = ERASED_WORD;
                end
                paddr_d = paddr_q + addr_t'(1);
                if (paddr_q == '1) begin
                    pre_d = 1'b0;
                end
                if (state_q == S_SECT_RUN && wr_ok) begin
                    if (cmd == CMD_RESET) begin
                        state_d = S_READ;
                    end else if (cmd == CMD_SUSPEND && !addr[0]) begin
                        timer_d = SUSPEND_CYC - 1;
                        state_d = S_SUSP_WAIT;
                    end
                end else if (timer_q >= ERASE_CYC && !pre_q && paddr_q == '1) begin
                    state_d = S_READ;
                end
            end
            S_SUSP_WAIT: begin
                timer_d = timer_q - 32'd1;
                if (timer_q == 32'd0) begin
                    state_d = S_SUSPENDED;
                end
            end
            S_SUSPENDED: begin
                if (wr_ok) begin
                    if (cmd == CMD_RESUME && !addr[0]) begin
                        state_d = S_SECT_RUN;
                    end else if (cmd == CMD_RESET) begin
                        state_d = S_READ;
                    end
                end
            end
            S_ERR: begin
                if (wr_ok && cmd == CMD_RESET) begin
                    err_d   = 1'b0;
                    state_d = idle_state(bypass_q);
                end
            end
        endcase
        if (wr_ok && cmd == CMD_RESET && !running && state_q != S_WINDOW
            && state_q != S_BYPASS && state_q != S_BYP_ARM && state_q != S_BYP_EXIT) begin
            state_d = S_READ;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= S_READ;
            erase_set_q <= '0;
            timer_q     <= '0;
            walk_q      <= '0;
            pre_q       <= 1'b0;
            err_q       <= 1'b0;
            tog_q       <= 1'b0;
            bypass_q    <= 1'b0;
            paddr_q     <= '0;
            pdata_q     <= '0;
        end else begin
            state_q     <= state_d;
            erase_set_q <= erase_set_d;
            timer_q     <= timer_d;
            walk_q      <= walk_d;
            pre_q       <= pre_d;
            err_q       <= err_d;
            tog_q       <= tog_d;
            bypass_q    <= bypass_d;
            paddr_q     <= paddr_d;
            pdata_q     <= pdata_d;
        end
    end

    // read answer: memory data or status word two cycles after the read strobe
    word_t status_w;
    logic  in_erase_sect;
    logic  stat_on;
    always_comb begin
        in_erase_sect = erase_set_q[sect_of(raddr_q)];
        status_w      = mem_rdata;
        stat_on       = 1'b1;
        if (state_q == S_PROG_RUN || (state_q == S_ERR && raddr_q == paddr_q)) begin
            status_w[POLL_BIT]   = ~pdata_q[POLL_BIT];
            status_w[TOGGLE_BIT] = tog_q;
            status_w[ERROR_BIT]  = err_q;
        end else if ((erasing || state_q == S_WINDOW || state_q == S_SUSP_WAIT)
                     && in_erase_sect) begin
            status_w[POLL_BIT]   = 1'b0;
            status_w[TOGGLE_BIT] = tog_q;
            status_w[ERROR_BIT]  = err_q;
            status_w[WINDOW_BIT] = (state_q != S_WINDOW);
        end else if (state_q == S_SUSPENDED && in_erase_sect) begin
            status_w = '0;
        end else begin
            stat_on = 1'b0;
        end
        // mirror only status words, array reads stay true
        if (stat_on) begin
            status_w[POLL_BIT+8]   = status_w[POLL_BIT];
            status_w[TOGGLE_BIT+8] = status_w[TOGGLE_BIT];
            status_w[ERROR_BIT+8]  = status_w[ERROR_BIT];
            status_w[WINDOW_BIT+8] = status_w[WINDOW_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_d1_q  <= 1'b0;
            raddr_q  <= '0;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
        end else begin
            rd_d1_q  <= rd_stb;
            raddr_q  <= addr;
            rvalid_q <= rd_d1_q;
            rdata_q  <= rd_d1_q ? status_w : rdata_q;
        end
    end

    window_bit_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_d1_q && state_q == S_WINDOW && in_erase_sect)
        |=> (!rdata_q[WINDOW_BIT] && !rdata_q[WINDOW_BIT+8]))
        else $error("window bit set while counting");
    bypass_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == S_BYPASS && wr_ok && cmd == CMD_RESET) |=> state_q == S_BYPASS)
        else $error("bypass left on stray command");
    err_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (err_q && !(wr_ok && cmd == CMD_RESET)) |=> err_q)
        else $error("error bit dropped");
    no_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == S_READ && !sel_s2_q) |=> state_q == S_READ)
        else $error("write counted without select");
    bulk_locked_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == S_BULK_RUN && wr_ok) |=> state_q != S_SUSP_WAIT)
        else $error("bulk erase took command");
    susp_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(state_q == S_SUSP_WAIT) |-> ##[1:150] state_q == S_SUSPENDED)
        else $error("suspend too slow");
    prog_ones_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (mem_we && state_q == S_PROG_RUN) |-> (mem_wdata == pdata_q))
        else $error("program raised a bit");
    window_cancel_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == S_WINDOW && wr_ok && cmd == CMD_UNLOCK1) |=> state_q == S_READ)
        else $error("window not cancelled");
endmodule : flash_program_erase_sequencer
`default_nettype wire

/* tb/mcu_bus_model.sv */
// microcontroller bus model: write and read cycles toward the sequencer
// assumes the sequencer samples on rising edges; this model moves on falling edges
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_model (
    input  wire logic                  core_clk,
    input  wire logic                  rvalid_q,
    input  wire flash_seq_pkg::word_t  rdata_q,
    output logic                       main_sector_select,
    output logic                       secondary_sector_select,
    output logic                       wr_stb,
    output logic                       rd_stb,
    output var   flash_seq_pkg::addr_t addr,
    output var   flash_seq_pkg::word_t wdata
);
    import flash_seq_pkg::*;
    logic sel_on = 1'b1;
    initial begin
        main_sector_select = 1'b0;
        secondary_sector_select = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = '0;
        wdata = '0;
    end
    // select raised three edges ahead so the synchroniser has caught it
    task automatic open_cycle(input addr_t a, input word_t d);
        logic pick;
        pick = 1'($urandom);
        @(negedge core_clk);
        main_sector_select = sel_on & pick;
        secondary_sector_select = sel_on & ~pick;
        addr = a;
        wdata = d;
        repeat (3) @(negedge core_clk);
    endtask : open_cycle
    // released bus shows inverted values so stale data cannot pass
    task automatic close_cycle();
        main_sector_select = 1'b0;
        secondary_sector_select = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endtask : close_cycle
    task automatic write_cycle(input addr_t a, input word_t d);
        open_cycle(a, d);
        wr_stb = 1'b1;
        @(negedge core_clk);
        wr_stb = 1'b0;
        close_cycle();
    endtask : write_cycle
    task automatic read_cycle(input addr_t a, output word_t q, output logic ok);
        open_cycle(a, 16'h0000);
        rd_stb = 1'b1;
        ok = 1'b0;
        q = '0;
        @(negedge core_clk);
        rd_stb = 1'b0;
        for (int i = 0; i < 5 && !ok; i++) begin
            if (rvalid_q === 1'b1) begin
                ok = 1'b1;
                q = rdata_q;
            end else begin
                @(negedge core_clk);
            end
        end
        close_cycle();
    endtask : read_cycle
endmodule : mcu_bus_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the flash command sequencer
// assumes mcu_bus_model as bus master and a short erase count
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_seq_pkg::*;
    logic core_clk, rstn, msel, ssel, wst, rds, rv, bsy;
    addr_t ad, a, b;
    word_t wd, rq, r0, r1, d, old;
    logic [15:0] prot;
    int err_total;
    int n_compared;

    flash_program_erase_sequencer #(.ERASE_CYC(50)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .main_sector_select(msel),
        .secondary_sector_select(ssel), .wr_stb(wst), .rd_stb(rds), .addr(ad),
        .wdata(wd), .sector_protect(prot), .rdata_q(rq), .rvalid_q(rv), .busy(bsy));
    mcu_bus_model mcu_u (.core_clk(core_clk), .rvalid_q(rv), .rdata_q(rq),
        .main_sector_select(msel), .secondary_sector_select(ssel), .wr_stb(wst),
        .rd_stb(rds), .addr(ad), .wdata(wd));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic fail(input string m);
        err_total++;
        $display("mismatch at %0t ns: %s", $time, m);
        complete_run();
    endtask : fail
    task automatic chk(input word_t g, input word_t e, input string m);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wc(input addr_t pa, input logic [7:0] c);
        mcu_u.write_cycle(pa, {8'h00, c});
    endtask : wc
    task automatic rc(input addr_t pa, output word_t q);
        logic ok;
        mcu_u.read_cycle(pa, q, ok);
        if (!ok) fail("read got no answer");
    endtask : rc
    task automatic unlock();
        wc(UNLOCK1_ADDR, CMD_UNLOCK1);
        wc(UNLOCK2_ADDR, CMD_UNLOCK2);
    endtask : unlock
    task automatic prog(input addr_t pa, input word_t pd);
        unlock();
        wc(UNLOCK1_ADDR, CMD_PROGRAM);
        mcu_u.write_cycle(pa, pd);
    endtask : prog
    task automatic erase_head();
        unlock();
        wc(UNLOCK1_ADDR, CMD_ERASE);
        unlock();
    endtask : erase_head
    task automatic idle(input int lim);
        for (int i = 0; i < lim && bsy !== 1'b0; i++) @(negedge core_clk);
        if (bsy !== 1'b0) fail("busy never dropped");
    endtask : idle
    task automatic poll(input addr_t pa, input word_t pd);
        for (int i = 0; i < 200; i++) begin
            rc(pa, r0);
            if (r0[ERROR_BIT] === 1'b1) rc(pa, r0);
            if (r0[POLL_BIT] === pd[POLL_BIT]) return;
        end
        fail("poll timed out");
    endtask : poll
    task automatic nb(input logic e, input string m);
        repeat (3) @(negedge core_clk);
        chk({15'h0000, bsy}, {15'h0000, e}, m);
    endtask : nb

    initial begin
        err_total = 0;
        n_compared = 0;
        rstn = 1'b0;
        prot = 16'h0000;
        void'($urandom(32'hc551));
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        erase_head();
        wc(UNLOCK1_ADDR, 8'h11);
        nb(1'b0, "bad bulk byte");
        erase_head();
        wc(UNLOCK1_ADDR, CMD_BULK);
        a = addr_t'($urandom) & 12'hFFE;
        rc(a, r0);
        rc(a, r1);
        chk(r0 & 16'h8080, 16'h0000, "erase poll");
        chk((r0 ^ r1) & 16'h4040, 16'h4040, "erase toggle");
        wc(a, CMD_RESET);
        nb(1'b1, "bulk refuses reset");
        idle(30000);
        rc(a, r0);
        chk(r0, ERASED_WORD, "bulk result");
        $display("test bulk erase done");
        prot = 16'h8000;
        for (int k = 0; k < 4; k++) begin
            a = {4'(k + 3), 8'($urandom)};
            d = word_t'($urandom) & 16'h7FFF;
            prog(a, d);
            rc(a, r0);
            chk(r0 & 16'h8080, d[7] ? 16'h0000 : 16'h8080, "program poll");
            poll(a, d);
            idle(2000);
            rc(a, r0);
            chk(r0, d, "program result");
            if (k == 0) begin
                b = a;
                old = d;
            end
        end
        prog(b, 16'hFFFF);
        r0 = 16'h0000;
        for (int i = 0; i < 200 && r0[ERROR_BIT] !== 1'b1; i++) rc(b, r0);
        chk(r0 & 16'h2020, 16'h2020, "zero to one error");
        repeat (PROG_TO_CYC + 100) @(negedge core_clk);
        rc(b, r0);
        chk(r0 & 16'h2020, 16'h2020, "error held");
        wc(b, CMD_RESET);
        idle(2000);
        rc(b, r0);
        chk(r0, old, "error cleared");
        $display("test program done");
        a = {4'hF, 8'($urandom)};
        prog(a, 16'h0000);
        mcu_u.sel_on = 1'b0;
        prog({4'hE, 8'h10}, 16'h0000);
        mcu_u.sel_on = 1'b1;
        nb(1'b0, "ignored programs");
        rc(a, r0);
        chk(r0, ERASED_WORD, "protected sector");
        rc({4'hE, 8'h10}, r0);
        chk(r0, ERASED_WORD, "unselected write");
        unlock();
        wc(UNLOCK1_ADDR, CMD_BYPASS);
        for (int k = 0; k < 2; k++) begin
            a = {4'hE, 8'(k * 2 + 32)};
            d = word_t'($urandom);
            wc(a, CMD_PROGRAM);
            mcu_u.write_cycle(a, d);
            poll(a, d);
            idle(2000);
            rc(a, r0);
            chk(r0, d, "bypass program");
            erase_head();
            wc(UNLOCK1_ADDR, CMD_BULK);
            nb(1'b0, "bypass ignores erase");
        end
        wc(12'h123, CMD_BYP_EXIT);
        wc(12'h456, CMD_BYP_EXIT2);
        a = {4'hE, 8'h40};
        wc(a, CMD_PROGRAM);
        mcu_u.write_cycle(a, 16'h0000);
        rc(a, r0);
        chk(r0, ERASED_WORD, "bypass left");
        $display("test bypass done");
        prog({4'h2, 8'h06}, 16'h0000);
        idle(2000);
        erase_head();
        wc({4'h1, 8'h00}, CMD_SECTOR);
        rc({4'h1, 8'h00}, r0);
        chk(r0 & 16'h0808, 16'h0000, "window open");
        repeat (WINDOW_CYC * 4 / 5) @(negedge core_clk);
        wc({4'h2, 8'h00}, CMD_SECTOR);
        repeat (WINDOW_CYC * 3 / 5) @(negedge core_clk);
        rc({4'h2, 8'h00}, r0);
        chk(r0 & 16'h0808, 16'h0000, "window restarted");
        for (int i = 0; i < 300 && r0[WINDOW_BIT] !== 1'b1; i++) rc({4'h2, 8'h00}, r0);
        chk(r0 & 16'h8888, 16'h0808, "erase running");
        wc({4'h1, 8'h02}, CMD_SUSPEND);
        repeat (SUSPEND_CYC + 10) @(negedge core_clk);
        rc({4'h1, 8'h04}, r0);
        rc({4'h1, 8'h04}, r1);
        chk((r0 ^ r1) & 16'h4040, 16'h0000, "suspend stops toggle");
        rc(b, r0);
        chk(r0, old, "other sector readable");
        prog(b ^ 12'h080, 16'h0000);
        repeat (PROG_CYC + 20) @(negedge core_clk);
        rc(b ^ 12'h080, r0);
        chk(r0, ERASED_WORD, "suspended program refused");
        wc({4'h1, 8'h00}, CMD_RESUME);
        rc({4'h1, 8'h04}, r0);
        rc({4'h1, 8'h04}, r1);
        chk((r0 ^ r1) & 16'h4040, 16'h4040, "resumed toggle");
        idle(30000);
        rc({4'h2, 8'h06}, r0);
        chk(r0, ERASED_WORD, "added sector erased");
        $display("test sector erase done");
        a = {4'h7, 8'h20};
        prog(a, 16'h1234);
        idle(2000);
        erase_head();
        wc(a, CMD_SECTOR);
        wc(UNLOCK1_ADDR, CMD_UNLOCK1);
        repeat (WINDOW_CYC + 200) @(negedge core_clk);
        idle(30000);
        rc(a, r0);
        chk(r0, 16'h1234, "window cancel");
        $display("test window cancel done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
